// ===== inc/xprio_pkg.sv
`include "xprio_regs.svh"
`default_nettype none

package xprio_pkg;

  typedef logic [`XPRIO_AXI_AW-1:0] axi_addr_t;
  typedef logic [`XPRIO_AXI_DW-1:0] axi_data_t;

  typedef struct packed {
    logic awvalid;
    axi_addr_t awaddr;
    logic wvalid;
    axi_data_t wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    axi_addr_t araddr;
    logic rready;
  } axil_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    axi_data_t rdata;
    logic [1:0] rresp;
  } axil_rsp_s;

  // one bit per source, 1 = high priority level
  typedef struct packed {
    logic clockValidIrqPriority;
    logic uartBIrqPriority;
    logic extIrqSevenPriority;
    logic extIrqSixPriority;
    logic converterBEocPriority;
    logic timerFourIrqPriority;
    logic converterAEocPriority;
    logic timerThreeIrqPriority;
  } prio_levels_s;

  typedef enum logic [3:0] {
    WR_IDLE = 4'h1,
    WR_HAVE_ADDR = 4'h2,
    WR_HAVE_DATA = 4'h4,
    WR_RESP = 4'h8
  } wr_phase_e;

  typedef struct packed {
    wr_phase_e phase;
    axi_addr_t awAddr;
    logic [7:0] wByte;
    logic wLane0;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [7:0] rByte;
    logic [1:0] rResp;
  } slave_state_s;

endpackage : xprio_pkg

`default_nettype wire

// ===== inc/xprio_regs.svh
// What this block does
// - bit 6 sets second UART interrupt priority: 0 low, 1 high
// - bit 5 sets external interrupt 7 priority: 0 low, 1 high
// - bit 4 sets external interrupt 6 priority: 0 low, 1 high
// - bit 3 sets second converter end-of-conversion priority: 0 low, 1 high
// - bit 2 sets Timer 4 priority; printed encoding doubtful, taken as 0 low, 1 high
// - bit 1 sets first converter end-of-conversion priority: 0 low, 1 high
// - bit 0 sets Timer 3 priority: 0 default fixed order, 1 high
`ifndef XPRIO_REGS_SVH
`define XPRIO_REGS_SVH

`define XPRIO_AXI_AW 12
`define XPRIO_AXI_DW 32
`define XPRIO_INDEX 12'h0F7
// byte address is four times the index
`define XPRIO_ADDR (`XPRIO_INDEX << 2)
`define XPRIO_RESET 8'h00

`define XPRIO_BIT_CLOCK_VALID 7
`define XPRIO_BIT_UART_B 6
`define XPRIO_BIT_EXT_SEVEN 5
`define XPRIO_BIT_EXT_SIX 4
`define XPRIO_BIT_CONV_B 3
`define XPRIO_BIT_TIMER_FOUR 2
`define XPRIO_BIT_CONV_A 1
`define XPRIO_BIT_TIMER_THREE 0

`define XPRIO_RESP_OKAY 2'h0
`define XPRIO_RESP_SLVERR 2'h2

`endif

// ===== sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "xprio_regs.svh"
`define CHK(nm, e, g) begin nCompared++; if ((g) !== (e)) begin nFail++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end

module tb;
  import xprio_pkg::*;
  typedef struct packed {
    logic [1:0] resp;
    logic [31:0] data;
  } note_s;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  axil_req_s axiReq = '0;
  axil_rsp_s axiRsp;
  prio_levels_s prioLevels;
  note_s wq[$];
  note_s rq[$];
  note_s n;
  int nFail = 0;
  int nCompared = 0;
  int seed = 26;
  int i;
  logic [7:0] model = 8'h00;
  logic [31:0] d;

  always #5 clock = ~clock;

  extended_irq_priority_reg_two u_extended_irq_priority_reg_two (
    .clock(clock),
    .rst_n(rst_n),
    .axiReq(axiReq),
    .axiRsp(axiRsp),
    .prioLevels(prioLevels)
  );

  task end_sim;
    if (nFail == 0 && nCompared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim

  // gap: idle cycles before address and data are offered together
  task wr(input logic [11:0] a, input logic [31:0] dt, input logic [3:0] s, input int gap);
    int k;
    bit awDone, wDone, bDone;
    bDone = 0;
    repeat (gap) @(posedge clock);
    @(posedge clock);
    if (a[11:2] == `XPRIO_INDEX) begin
      if (s[0]) model = dt[7:0];
      wq.push_back({`XPRIO_RESP_OKAY, 24'h0, model});
    end else wq.push_back({`XPRIO_RESP_SLVERR, 24'h0, model});
    axiReq.awaddr <= a;
    axiReq.wdata <= dt;
    axiReq.wstrb <= s;
    axiReq.bready <= 1'b1;
    axiReq.awvalid <= 1'b1;
    axiReq.wvalid <= 1'b1;
    for (k = 0; k < 50 && !bDone; k++) begin
      @(negedge clock);
      awDone = axiReq.awvalid && axiRsp.awready;
      wDone = axiReq.wvalid && axiRsp.wready;
      bDone = axiReq.bready && axiRsp.bvalid;
      @(posedge clock);
      if (awDone) axiReq.awvalid <= 1'b0;
      if (wDone) axiReq.wvalid <= 1'b0;
      if (bDone) axiReq.bready <= 1'b0;
    end
    if (!bDone) begin
      nFail++;
      end_sim;
    end
  endtask : wr

  task rd(input logic [11:0] a);
    int k;
    bit arDone, rDone;
    rDone = 0;
    @(posedge clock);
    if (a[11:2] == `XPRIO_INDEX) rq.push_back({`XPRIO_RESP_OKAY, 24'h0, model});
    else rq.push_back({`XPRIO_RESP_SLVERR, 32'h0});
    axiReq.araddr <= a;
    axiReq.arvalid <= 1'b1;
    axiReq.rready <= 1'b1;
    for (k = 0; k < 50 && !rDone; k++) begin
      @(negedge clock);
      arDone = axiReq.arvalid && axiRsp.arready;
      rDone = axiReq.rready && axiRsp.rvalid;
      @(posedge clock);
      if (arDone) axiReq.arvalid <= 1'b0;
      if (rDone) axiReq.rready <= 1'b0;
    end
    if (!rDone) begin
      nFail++;
      end_sim;
    end
  endtask : rd

  // takes the oldest note whenever a response is handed over
  always @(negedge clock) begin
    if (axiRsp.bvalid && axiReq.bready) begin
      if (wq.size() == 0) `CHK("write note", 1'b1, 1'b0)
      else begin
        n = wq.pop_front();
        `CHK("bresp", n.resp, axiRsp.bresp)
        `CHK("prioLevels", n.data[7:0], prioLevels)
      end
    end
    if (axiRsp.rvalid && axiReq.rready) begin
      if (rq.size() == 0) `CHK("read note", 1'b1, 1'b0)
      else begin
        n = rq.pop_front();
        `CHK("rresp", n.resp, axiRsp.rresp)
        `CHK("rdata", n.data, axiRsp.rdata)
      end
    end
  end

  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    @(negedge clock);
    `CHK("reset prioLevels", 8'h00, prioLevels)
    `CHK("reset readies", 3'b111, {axiRsp.awready, axiRsp.wready, axiRsp.arready})
    `CHK("reset valids", 2'b00, {axiRsp.bvalid, axiRsp.rvalid})
    rd(`XPRIO_ADDR);
    // one bit at a time, with varying idle gaps
    for (i = 0; i < 8; i++) begin
      wr(`XPRIO_ADDR, 32'h1 << i, 4'hF, i % 3);
      rd(`XPRIO_ADDR);
    end
    wr(`XPRIO_ADDR, 32'h0000_00FF, 4'h1, 0);
    wr(`XPRIO_ADDR, 32'h0000_0000, 4'hE, 1);
    rd(`XPRIO_ADDR);
    for (i = 0; i < 12; i++) begin
      d = $random(seed);
      wr(`XPRIO_ADDR + {10'h0, d[9:8]}, d, d[13:10], d[17:16] % 3);
      rd(`XPRIO_ADDR + {10'h0, d[21:20]});
    end
    // unmapped places answer with an error and leave the register alone
    wr(12'h3E0, 32'h0000_005A, 4'hF, 2);
    rd(12'h3E0);
    rd(12'h000);
    rd(`XPRIO_ADDR);
    // reset in mid-run clears every level
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    model = 8'h00;
    @(negedge clock);
    `CHK("reset prioLevels", 8'h00, prioLevels)
    `CHK("reset readies", 3'b111, {axiRsp.awready, axiRsp.wready, axiRsp.arready})
    `CHK("reset valids", 2'b00, {axiRsp.bvalid, axiRsp.rvalid})
    rd(`XPRIO_ADDR);
    repeat (3) @(posedge clock);
    `CHK("notes left", 0, wq.size() + rq.size())
    end_sim;
  end
endmodule : tb
`default_nettype wire

// ===== verilog/extended_irq_priority_reg_two.sv
`timescale 1ns/1ps
`default_nettype none

module extended_irq_priority_reg_two
  import xprio_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire axil_req_s axiReq,
  output axil_rsp_s axiRsp,
  output prio_levels_s prioLevels
);

  slave_state_s state_r;
  slave_state_s state_nxt;

  logic awFire;
  logic wFire;
  logic arFire;
  logic commit;
  axi_addr_t commitAddr;
  logic [7:0] commitByte;
  logic commitLane0;
  logic commitHit;
  logic readHit;
  logic wrEn;
  logic [7:0] wrData;
  logic [7:0] prioByte;

  // handshake readies are combinational, answers come from flops
  always_comb begin
    axiRsp.awready = (state_r.phase == WR_IDLE) || (state_r.phase == WR_HAVE_DATA);
    axiRsp.wready = (state_r.phase == WR_IDLE) || (state_r.phase == WR_HAVE_ADDR);
    axiRsp.bvalid = state_r.bValid;
    axiRsp.bresp = state_r.bResp;
    axiRsp.arready = !state_r.rValid;
    axiRsp.rvalid = state_r.rValid;
    axiRsp.rdata = {24'h00_0000, state_r.rByte};
    axiRsp.rresp = state_r.rResp;
  end

  assign awFire = axiReq.awvalid && axiRsp.awready;
  assign wFire = axiReq.wvalid && axiRsp.wready;
  assign arFire = axiReq.arvalid && axiRsp.arready;

  // a write completes once both address and data are in hand
  always_comb begin
    commit = 1'b0;
    unique case (state_r.phase)
      WR_IDLE: commit = awFire && wFire;
      WR_HAVE_ADDR: commit = wFire;
      WR_HAVE_DATA: commit = awFire;
      WR_RESP: commit = 1'b0;
    endcase
  end

  assign commitAddr = (state_r.phase == WR_HAVE_ADDR) ? state_r.awAddr : axiReq.awaddr;
  assign commitByte = (state_r.phase == WR_HAVE_DATA) ? state_r.wByte : axiReq.wdata[7:0];
  assign commitLane0 = (state_r.phase == WR_HAVE_DATA) ? state_r.wLane0 : axiReq.wstrb[0];
  // word address bits against the register index; byte lane bits ignored
  assign commitHit = commitAddr[`XPRIO_AXI_AW-1:2] == 10'(`XPRIO_INDEX);
  assign readHit = axiReq.araddr[`XPRIO_AXI_AW-1:2] == 10'(`XPRIO_INDEX);

  // only byte lane 0 carries register bits; other lanes are ignored
  assign wrEn = commit && commitHit && commitLane0;
  assign wrData = commitByte;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r.phase)
      WR_IDLE: begin
        if (commit) begin
          state_nxt.phase = WR_RESP;
        end else if (awFire) begin
          state_nxt.phase = WR_HAVE_ADDR;
          state_nxt.awAddr = axiReq.awaddr;
        end else if (wFire) begin
          state_nxt.phase = WR_HAVE_DATA;
          state_nxt.wByte = axiReq.wdata[7:0];
          state_nxt.wLane0 = axiReq.wstrb[0];
        end
      end
      WR_HAVE_ADDR: begin
        if (commit) begin
          state_nxt.phase = WR_RESP;
        end
      end
      WR_HAVE_DATA: begin
        if (commit) begin
          state_nxt.phase = WR_RESP;
        end
      end
      WR_RESP: begin
        if (axiReq.bready) begin
          state_nxt.phase = WR_IDLE;
          state_nxt.bValid = 1'b0;
        end
      end
    endcase
    if (commit) begin
      state_nxt.bValid = 1'b1;
      state_nxt.bResp = commitHit ? `XPRIO_RESP_OKAY : `XPRIO_RESP_SLVERR;
    end
    if (arFire) begin
      state_nxt.rValid = 1'b1;
      state_nxt.rByte = readHit ? prioByte : 8'h00;
      state_nxt.rResp = readHit ? `XPRIO_RESP_OKAY : `XPRIO_RESP_SLVERR;
    end else if (state_r.rValid && axiReq.rready) begin
      state_nxt.rValid = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_r.phase <= WR_IDLE;
      state_r.awAddr <= '0;
      state_r.wByte <= 8'h00;
      state_r.wLane0 <= 1'b0;
      state_r.bValid <= 1'b0;
      state_r.bResp <= `XPRIO_RESP_OKAY;
      state_r.rValid <= 1'b0;
      state_r.rByte <= 8'h00;
      state_r.rResp <= `XPRIO_RESP_OKAY;
    end else begin
      state_r <= state_nxt;
    end
  end

  prio_byte_store u_store (
    .clock(clock),
    .rst_n(rst_n),
    .wrEn(wrEn),
    .wrData(wrData),
    .prioByte(prioByte),
    .prioLevels(prioLevels)
  );

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  a_clock_valid_level: assert property (
    wrEn |=> prioLevels.clockValidIrqPriority == $past(wrData[`XPRIO_BIT_CLOCK_VALID])
  ) else $error("clock valid priority did not follow write");

  a_uart_b_level: assert property (
    wrEn |=> prioLevels.uartBIrqPriority == $past(axiReq.wvalid && axiRsp.wready
      ? axiReq.wdata[`XPRIO_BIT_UART_B] : state_r.wByte[`XPRIO_BIT_UART_B])
  ) else $error("uart b priority did not follow write");

  a_ext_seven_level: assert property (
    (wrEn && wrData[`XPRIO_BIT_EXT_SEVEN]) ##1 !wrEn [*2] |-> prioLevels.extIrqSevenPriority
  ) else $error("ext irq seven high level not held");

  a_ext_six_level: assert property (
    (wrEn && !wrData[`XPRIO_BIT_EXT_SIX]) |=> !prioLevels.extIrqSixPriority
  ) else $error("ext irq six low level not taken");

  a_conv_b_level: assert property (
    wrEn |=> prioLevels.converterBEocPriority == $past(commitByte[`XPRIO_BIT_CONV_B])
  ) else $error("converter b priority did not follow write");

  a_timer_four_level: assert property (
    (wrEn && wrData[`XPRIO_BIT_TIMER_FOUR]) |=> prioLevels.timerFourIrqPriority
  ) else $error("timer four one must give high level");

  a_conv_a_level: assert property (
    wrEn |=> prioLevels.converterAEocPriority == $past(wrData[`XPRIO_BIT_CONV_A])
  ) else $error("converter a priority did not follow write");

  a_timer_three_level: assert property (
    wrEn |=> prioLevels.timerThreeIrqPriority == $past(wrData[`XPRIO_BIT_TIMER_THREE])
  ) else $error("timer three priority did not follow write");

  a_levels_hold: assert property (
    !wrEn |=> $stable(prioLevels)
  ) else $error("priority levels changed without a write");

  a_read_shows_reg: assert property (
    (arFire && readHit) |=> axiRsp.rvalid && axiRsp.rdata[7:0] == $past(prioByte)
  ) else $error("read data does not show the register");

  a_write_answer: assert property (
    commit |=> axiRsp.bvalid && axiRsp.bresp == ($past(commitHit) ? `XPRIO_RESP_OKAY : `XPRIO_RESP_SLVERR)
  ) else $error("write response missing after commit");

  a_bvalid_held: assert property (
    (axiRsp.bvalid && !axiReq.bready) |=> axiRsp.bvalid && $stable(axiRsp.bresp)
  ) else $error("write response dropped before bready");

  a_unmapped_err: assert property (
    (arFire && !readHit) |=> axiRsp.rresp == `XPRIO_RESP_SLVERR && axiRsp.rdata == '0
  ) else $error("unmapped read not answered with slverr");

  a_rvalid_held: assert property (
    (axiRsp.rvalid && !axiReq.rready) |=> axiRsp.rvalid && $stable(axiRsp.rdata) && $stable(axiRsp.rresp)
  ) else $error("read response dropped before rready");

  a_busy_refuses: assert property (
    axiRsp.bvalid |-> !axiRsp.awready && !axiRsp.wready
  ) else $error("write channels open while response pending");

  a_lane_off_keeps: assert property (
    (commit && !commitLane0) |=> $stable(prioLevels)
  ) else $error("write without byte lane 0 changed levels");

  a_bvalid_source: assert property (
    $rose(axiRsp.bvalid) |-> $past(commit)
  ) else $error("write response without a commit");

  c_write_same_cycle: cover property (
    state_r.phase == WR_IDLE && awFire && wFire ##1 axiRsp.bvalid
  );

  c_data_before_addr: cover property (
    state_r.phase == WR_HAVE_DATA ##[1:4] commit
  );

  c_read_back_high: cover property (
    wrEn && wrData == 8'hFF ##[1:8] (arFire && readHit)
  );

  c_unmapped_write: cover property (
    commit && !commitHit
  );

  c_lane_off_write: cover property (
    commit && commitHit && !commitLane0
  );

endmodule : extended_irq_priority_reg_two

`default_nettype wire

// ===== verilog/prio_byte_store.sv
`timescale 1ns/1ps
`default_nettype none

module prio_byte_store
  import xprio_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic wrEn,
  input wire logic [7:0] wrData,
  output logic [7:0] prioByte,
  output prio_levels_s prioLevels
);

  prio_levels_s state_r;
  prio_levels_s state_nxt;
  logic [7:0] nextBits;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_bit
      // each source level follows its own bit
      assign nextBits[gi] = wrEn ? wrData[gi] : state_r[gi];
    end
  endgenerate

  always_comb begin
    state_nxt = prio_levels_s'(nextBits);
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_r <= prio_levels_s'(`XPRIO_RESET);
    end else begin
      state_r <= state_nxt;
    end
  end

  assign prioByte = 8'(state_r);
  assign prioLevels = state_r;

endmodule : prio_byte_store

`default_nettype wire
